// *** hdl/sco_ctrl.sv ***
// Supervisor control operations: reset pulse, exception return, stop
`timescale 1ns/100ps
module sco_ctrl #(
   parameter int unsigned LONG_CNT  = sco_pkg::PULSE_LONG,
   parameter int unsigned SHORT_CNT = sco_pkg::PULSE_SHORT
) (
   // Clock and reset
   input  wire logic                 clk_sys_in,
   input  wire logic                 resetn_in,
   // APB slave
   input  wire logic                 psel_in,
   input  wire logic                 penable_in,
   input  wire logic                 pwrite_in,
   input  wire logic [7:0]           paddr_in,
   input  wire logic [31:0]          pwdata_in,
   output logic [31:0]               prdata_out,
   output logic                      pready_out,
   output logic                      pslverr_out,
   // Instruction issue
   input  wire logic                 issue_valid_in,
   input  wire logic [15:0]          opcode_in,
   input  wire logic [15:0]          imm_in,
   output logic                      issue_ready_out,
   output logic                      done_out,
   // Stack read port
   output sco_pkg::sco_mem_req_t     mem_out,
   input  wire logic                 mem_ack_in,
   input  wire logic [15:0]          mem_data_in,
   // Wake sources
   input  wire logic [2:0]           irq_level_in,
   input  wire logic                 ext_reset_in,
   // Results
   output logic                      reset_out_line_out,
   output sco_pkg::sco_exc_t         exc_out,
   output logic [15:0]               status_word_out,
   output logic                      stopped_out,
   output logic                      irq_out
);
   typedef struct packed {
      sco_pkg::sco_fsm_t           fsm;
      logic [15:0]                 status_word;
      logic [31:0]                 pc;
      logic [31:0]                 sp;
      logic [15:0]                 tmp_sw;
      logic [31:0]                 tmp_pc;
      logic                        short_mode;
      logic [sco_pkg::EV_W-1:0]    ev_stat;
      logic [sco_pkg::EV_W-1:0]    ev_mask;
      logic [31:0]                 rdata;
      logic                        acc_seen;
      logic                        done;
      sco_pkg::sco_exc_t           exc;
   } sco_st_t;

   sco_st_t st;
   sco_st_t next_st;
   logic    pulse_start;
   logic    pulse_line;
   logic    pulse_done;
   logic    apb_acc;
   logic    is_sup;
   logic    priv_op;
   logic    trace_on;
   logic [sco_pkg::EV_W-1:0] ev_set;
   logic [31:0] rest;
   logic        fmt_ok;

   ////////////////////////////////////////////////////////////////////////
   // Reset line timer
   sco_pulse #(
      .LONG_CNT  (LONG_CNT),
      .SHORT_CNT (SHORT_CNT)
   ) u_pulse (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .start_in   (pulse_start),
      .short_in   (st.short_mode),
      .line_out   (pulse_line),
      .done_out   (pulse_done)
   );

   assign apb_acc = psel_in && penable_in;
   assign is_sup  = st.status_word[sco_pkg::SW_S];
   assign priv_op = (opcode_in == sco_pkg::OP_RESET) ||
                    (opcode_in == sco_pkg::OP_STOP)  ||
                    (opcode_in == sco_pkg::OP_RTE);
   assign trace_on = st.status_word[sco_pkg::SW_T0] &&
                     !st.status_word[sco_pkg::SW_T1];

   ////////////////////////////////////////////////////////////////////////
   // Frame size by format code
   always_comb begin
      fmt_ok = 1'b1;
      case (mem_data_in[sco_pkg::FMT_H:sco_pkg::FMT_L])
         sco_pkg::FMT_0: rest = sco_pkg::REST_F0;
         sco_pkg::FMT_2: rest = sco_pkg::REST_F2;
         sco_pkg::FMT_9: rest = sco_pkg::REST_F9;
         sco_pkg::FMT_A: rest = sco_pkg::REST_FA;
         sco_pkg::FMT_B: rest = sco_pkg::REST_FB;
         default: begin
            rest   = '0;
            fmt_ok = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer and registers
   always_comb begin
      next_st     = st;
      next_st.done = 1'b0;
      next_st.exc  = '0;
      next_st.acc_seen = apb_acc && !st.acc_seen;
      pulse_start = 1'b0;
      ev_set      = '0;
      case (st.fsm)
         sco_pkg::SCO_IDLE: begin
            if (issue_valid_in && priv_op && !is_sup) begin
               next_st.exc.valid = 1'b1;
               next_st.exc.kind  = sco_pkg::SCO_EXC_PRIV;
               ev_set[sco_pkg::EV_PRIV] = 1'b1;
               next_st.done = 1'b1;
            end else if (issue_valid_in) begin
               case (opcode_in)
                  sco_pkg::OP_RESET: begin
                     pulse_start = 1'b1;
                     next_st.fsm = sco_pkg::SCO_PULSE;
                  end
                  sco_pkg::OP_RTE: begin
                     next_st.fsm = sco_pkg::SCO_POP_SW;
                  end
                  sco_pkg::OP_STOP: begin
                     next_st.status_word = imm_in;
                     next_st.pc = st.pc + {16'h0000, sco_pkg::PC_STEP_TWO};
                     if (trace_on) begin
                        next_st.exc.valid = 1'b1;
                        next_st.exc.kind  = sco_pkg::SCO_EXC_TRACE;
                        ev_set[sco_pkg::EV_WAKE] = 1'b1;
                        next_st.done = 1'b1;
                     end else begin
                        next_st.fsm = sco_pkg::SCO_STOPPED;
                     end
                  end
                  default: begin
                     next_st.done = 1'b1;
                  end
               endcase
            end
         end
         sco_pkg::SCO_PULSE: begin
            if (pulse_done) begin
               next_st.pc = st.pc + {16'h0000, sco_pkg::PC_STEP_ONE};
               next_st.fsm = sco_pkg::SCO_IDLE;
               next_st.done = 1'b1;
               ev_set[sco_pkg::EV_PULSE] = 1'b1;
            end
         end
         sco_pkg::SCO_POP_SW: begin
            if (mem_ack_in) begin
               next_st.tmp_sw = mem_data_in;
               next_st.sp  = st.sp + sco_pkg::STEP_SW;
               next_st.fsm = sco_pkg::SCO_POP_PCH;
            end
         end
         sco_pkg::SCO_POP_PCH: begin
            if (mem_ack_in) begin
               next_st.tmp_pc[31:16] = mem_data_in;
               next_st.fsm = sco_pkg::SCO_POP_PCL;
            end
         end
         sco_pkg::SCO_POP_PCL: begin
            if (mem_ack_in) begin
               next_st.tmp_pc[15:0] = mem_data_in;
               next_st.sp  = st.sp + sco_pkg::STEP_PC;
               next_st.fsm = sco_pkg::SCO_POP_FMT;
            end
         end
         sco_pkg::SCO_POP_FMT: begin
            if (mem_ack_in) begin
               next_st.fsm  = sco_pkg::SCO_IDLE;
               next_st.done = 1'b1;
               if (fmt_ok) begin
                  next_st.sp = st.sp + rest;
                  next_st.status_word = st.tmp_sw;
                  next_st.pc = st.tmp_pc;
               end else begin
                  // Bad frame leaves state alone for the handler
                  next_st.sp = st.sp - sco_pkg::STEP_SW
                               - sco_pkg::STEP_PC;
                  next_st.exc.valid = 1'b1;
                  next_st.exc.kind  = sco_pkg::SCO_EXC_FORMAT;
                  ev_set[sco_pkg::EV_FMT] = 1'b1;
               end
            end
         end
         sco_pkg::SCO_STOPPED: begin
            if (ext_reset_in) begin
               next_st.exc.valid = 1'b1;
               next_st.exc.kind  = sco_pkg::SCO_EXC_RESET;
               next_st.fsm  = sco_pkg::SCO_IDLE;
               next_st.done = 1'b1;
               ev_set[sco_pkg::EV_WAKE] = 1'b1;
            end else if (irq_level_in >
                  st.status_word[sco_pkg::SW_IM_H:sco_pkg::SW_IM_L]) begin
               next_st.exc.valid = 1'b1;
               next_st.exc.kind  = sco_pkg::SCO_EXC_IRQ;
               next_st.exc.level = irq_level_in;
               next_st.fsm  = sco_pkg::SCO_IDLE;
               next_st.done = 1'b1;
               ev_set[sco_pkg::EV_WAKE] = 1'b1;
            end
         end
         default: begin
            next_st.fsm = sco_pkg::SCO_IDLE;
         end
      endcase

      // APB access phase; writes land on the answering edge only
      if (pready_out && pwrite_in) begin
         case (paddr_in)
            sco_pkg::A_CTRL:  next_st.short_mode = pwdata_in[0];
            sco_pkg::A_SW: begin
               if (st.fsm == sco_pkg::SCO_IDLE)
                  next_st.status_word = pwdata_in[15:0];
            end
            sco_pkg::A_PC: begin
               if (st.fsm == sco_pkg::SCO_IDLE) next_st.pc = pwdata_in;
            end
            sco_pkg::A_SP: begin
               if (st.fsm == sco_pkg::SCO_IDLE) next_st.sp = pwdata_in;
            end
            sco_pkg::A_ISTAT:
               next_st.ev_stat = st.ev_stat & ~pwdata_in[sco_pkg::EV_W-1:0];
            sco_pkg::A_IMASK:
               next_st.ev_mask = pwdata_in[sco_pkg::EV_W-1:0];
            sco_pkg::A_STATE: ;
            default: ;
         endcase
      end else if (apb_acc && !pwrite_in) begin
         case (paddr_in)
            sco_pkg::A_CTRL:  next_st.rdata = {31'h0000_0000, st.short_mode};
            sco_pkg::A_SW:    next_st.rdata = {16'h0000, st.status_word};
            sco_pkg::A_PC:    next_st.rdata = st.pc;
            sco_pkg::A_SP:    next_st.rdata = st.sp;
            sco_pkg::A_ISTAT: next_st.rdata = {28'h000_0000, st.ev_stat};
            sco_pkg::A_IMASK: next_st.rdata = {28'h000_0000, st.ev_mask};
            sco_pkg::A_STATE: next_st.rdata = {27'h000_0000, pulse_line,
                                               1'b0, st.fsm};
            default: next_st.rdata = '0;
         endcase
      end

      // Hardware set wins over a clear in the same cycle
      next_st.ev_stat = next_st.ev_stat | ev_set;
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st             <= '0;
         st.status_word <= sco_pkg::SW_RESET;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   // Read data is registered, so the answer costs one wait cycle
   // Unmapped addresses still answer, reading zero and ignoring writes
   assign pready_out  = apb_acc && st.acc_seen;

   assign prdata_out  = st.rdata;
   assign pslverr_out = 1'b0;

   assign issue_ready_out    = (st.fsm == sco_pkg::SCO_IDLE);
   assign done_out           = st.done;
   assign mem_out.req        = (st.fsm == sco_pkg::SCO_POP_SW)  ||
                               (st.fsm == sco_pkg::SCO_POP_PCH) ||
                               (st.fsm == sco_pkg::SCO_POP_PCL) ||
                               (st.fsm == sco_pkg::SCO_POP_FMT);
   assign mem_out.addr       = (st.fsm == sco_pkg::SCO_POP_PCL) ?
                               st.sp + sco_pkg::STEP_HW : st.sp;
   assign reset_out_line_out = pulse_line;
   assign exc_out            = st.exc;
   assign status_word_out    = st.status_word;
   assign stopped_out        = (st.fsm == sco_pkg::SCO_STOPPED);
   assign irq_out            = |(st.ev_stat & st.ev_mask);
endmodule : sco_ctrl

// *** hdl/sco_pkg.sv ***
// Constants, types and register map of the supervisor control operations
package sco_pkg;
   // Opcodes
   localparam logic [15:0] OP_RESET = 16'h4E70;
   localparam logic [15:0] OP_STOP  = 16'h4E72;
   localparam logic [15:0] OP_RTE   = 16'h4E73;
   // Pulse lengths in processor clocks
   localparam int unsigned PULSE_LONG  = 512;
   localparam int unsigned PULSE_SHORT = 124;
   localparam int unsigned PULSE_W     = 10;
   // Status word fields
   localparam int unsigned SW_T1   = 15;
   localparam int unsigned SW_T0   = 14;
   localparam int unsigned SW_S    = 13;
   localparam int unsigned SW_IM_H = 10;
   localparam int unsigned SW_IM_L = 8;
   localparam int unsigned SW_FL_H = 7;
   localparam logic [15:0] SW_RESET = 16'h2700;
   // Frame format field
   localparam int unsigned FMT_H = 15;
   localparam int unsigned FMT_L = 12;
   // Stack steps and remaining bytes per format after the first six
   localparam logic [31:0] STEP_SW = 32'h0000_0002;
   localparam logic [31:0] STEP_PC = 32'h0000_0004;
   localparam logic [31:0] STEP_HW = 32'h0000_0002;
   localparam logic [31:0] REST_F0 = 32'h0000_0002;
   localparam logic [31:0] REST_F2 = 32'h0000_0006;
   localparam logic [31:0] REST_F9 = 32'h0000_000E;
   localparam logic [31:0] REST_FA = 32'h0000_001A;
   localparam logic [31:0] REST_FB = 32'h0000_0056;
   localparam logic [3:0]  FMT_0 = 4'h0;
   localparam logic [3:0]  FMT_2 = 4'h2;
   localparam logic [3:0]  FMT_9 = 4'h9;
   localparam logic [3:0]  FMT_A = 4'hA;
   localparam logic [3:0]  FMT_B = 4'hB;
   localparam logic [15:0] PC_STEP_ONE = 16'h0002;
   localparam logic [15:0] PC_STEP_TWO = 16'h0004;
   // APB register byte addresses
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_SW    = 8'h04;
   localparam logic [7:0] A_PC    = 8'h08;
   localparam logic [7:0] A_SP    = 8'h0C;
   localparam logic [7:0] A_ISTAT = 8'h10;
   localparam logic [7:0] A_IMASK = 8'h14;
   localparam logic [7:0] A_STATE = 8'h18;
   // Interrupt event bits
   localparam int unsigned EV_PULSE = 0;
   localparam int unsigned EV_PRIV  = 1;
   localparam int unsigned EV_WAKE  = 2;
   localparam int unsigned EV_FMT   = 3;
   localparam int unsigned EV_W     = 4;

   typedef enum logic [2:0] {
      SCO_EXC_NONE, SCO_EXC_PRIV, SCO_EXC_TRACE, SCO_EXC_IRQ,
      SCO_EXC_RESET, SCO_EXC_FORMAT
   } sco_exc_kind_t;

   typedef struct packed {
      logic          valid;
      sco_exc_kind_t kind;
      logic [2:0]    level;
   } sco_exc_t;

   typedef struct packed {
      logic        req;
      logic [31:0] addr;
   } sco_mem_req_t;

   typedef enum logic [2:0] {
      SCO_IDLE, SCO_PULSE, SCO_POP_SW, SCO_POP_PCH, SCO_POP_PCL,
      SCO_POP_FMT, SCO_STOPPED
   } sco_fsm_t;
endpackage : sco_pkg

// *** hdl/sco_pulse.sv ***
// Reset line pulse timer
`timescale 1ns/100ps
module sco_pulse #(
   parameter int unsigned LONG_CNT  = sco_pkg::PULSE_LONG,
   parameter int unsigned SHORT_CNT = sco_pkg::PULSE_SHORT
) (
   // Clock and reset
   input  wire logic clk_sys_in,
   input  wire logic resetn_in,
   // Control
   input  wire logic start_in,
   input  wire logic short_in,
   // Line and completion
   output logic      line_out,
   output logic      done_out
);
   typedef struct packed {
      logic [sco_pkg::PULSE_W-1:0] cnt;
      logic                        active;
      logic                        done;
   } sco_pulse_st_t;

   sco_pulse_st_t st;
   sco_pulse_st_t next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (st.active) begin
         if (st.cnt == '0) begin
            next_st.active = 1'b0;
            next_st.done   = 1'b1;
         end else begin
            next_st.cnt = st.cnt - 1'b1;
         end
      end else if (start_in) begin
         next_st.active = 1'b1;
         next_st.cnt = short_in ? sco_pulse_w(SHORT_CNT - 1)
                                : sco_pulse_w(LONG_CNT - 1);
      end
   end

   function automatic logic [sco_pkg::PULSE_W-1:0] sco_pulse_w(
      input int unsigned v);
      sco_pulse_w = v[sco_pkg::PULSE_W-1:0];
   endfunction : sco_pulse_w

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign line_out = st.active;
   assign done_out = st.done;
endmodule : sco_pulse

// *** verif/sco_ctrl_monitor.sv ***
// Port checker for the supervisor control operations block
`timescale 1ns/100ps
module sco_ctrl_monitor #(
   parameter int unsigned LONG_CNT  = 512,
   parameter int unsigned SHORT_CNT = 124
) (
   // Clock and reset
   input wire logic              clk_sys_in,
   input wire logic              resetn_in,
   // Bus and issue
   input wire logic              psel_in,
   input wire logic              penable_in,
   input wire logic              pready_out,
   input wire logic              issue_valid_in,
   input wire logic [15:0]       opcode_in,
   input wire logic [15:0]       imm_in,
   input wire logic              issue_ready_out,
   input wire logic              done_out,
   // Wake and results
   input wire logic [2:0]        irq_level_in,
   input wire logic              ext_reset_in,
   input wire logic              reset_out_line_out,
   input wire sco_pkg::sco_exc_t exc_out,
   input wire logic [15:0]       status_word_out,
   input wire logic              stopped_out
);
   logic [9:0]  hi_cnt;
   logic [15:0] imm_q;
   logic        take;
   logic        sup;
   logic        stop_op;
   logic        priv_op;
   assign take = issue_valid_in && issue_ready_out;
   assign sup = status_word_out[sco_pkg::SW_S];
   assign stop_op = take && sup && opcode_in == sco_pkg::OP_STOP;
   assign priv_op = opcode_in == sco_pkg::OP_RESET
                 || opcode_in == sco_pkg::OP_STOP
                 || opcode_in == sco_pkg::OP_RTE;
   // Pulse length and stop operand
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         hi_cnt <= 10'h000;
         imm_q  <= 16'h0000;
      end else begin
         hi_cnt <= reset_out_line_out ? hi_cnt + 10'h001 : 10'h000;
         if (take) begin
            imm_q <= imm_in;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   property p_pulse_len;
      $fell(reset_out_line_out) |->
         hi_cnt == 10'(LONG_CNT) || hi_cnt == 10'(SHORT_CNT);
   endproperty
   property p_pulse_start;
      take && sup && opcode_in == sco_pkg::OP_RESET |=> reset_out_line_out;
   endproperty
   property p_priv;
      take && !sup && priv_op |=> exc_out.valid && !reset_out_line_out
         && exc_out.kind == sco_pkg::SCO_EXC_PRIV && $stable(status_word_out);
   endproperty
   property p_stop_load;
      stop_op && status_word_out[15:14] != 2'h1
         |-> ##[1:2] stopped_out && status_word_out == imm_q;
   endproperty
   property p_trace;
      stop_op && status_word_out[15:14] == 2'h1
         |-> ##[1:2] exc_out.valid && exc_out.kind == sco_pkg::SCO_EXC_TRACE;
   endproperty
   property p_hold;
      stopped_out && !ext_reset_in && irq_level_in <= status_word_out[10:8]
         |=> stopped_out;
   endproperty
   property p_wake;
      stopped_out && !ext_reset_in && irq_level_in > status_word_out[10:8]
         |=> exc_out.valid && exc_out.kind == sco_pkg::SCO_EXC_IRQ
         && exc_out.level == $past(irq_level_in);
   endproperty
   property p_ext_reset;
      stopped_out && ext_reset_in
         |=> exc_out.valid && exc_out.kind == sco_pkg::SCO_EXC_RESET;
   endproperty
   property p_done_one;
      done_out |=> !done_out;
   endproperty
   property p_pready;
      psel_in && !penable_in ##1 psel_in && penable_in
         |-> !pready_out ##1 pready_out;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset line pulse has a wrong length");
   a_pulse_start: assert property (p_pulse_start)
      else $error("reset line did not rise after issue");
   a_priv: assert property (p_priv)
      else $error("privileged op outside supervisor not trapped");
   a_stop_load: assert property (p_stop_load)
      else $error("stop did not load status word and halt");
   a_trace: assert property (p_trace)
      else $error("stop with tracing gave no trace exception");
   a_hold: assert property (p_hold)
      else $error("stopped core woke without cause");
   a_wake: assert property (p_wake)
      else $error("interrupt above mask did not wake core");
   a_ext_reset: assert property (p_ext_reset)
      else $error("external reset did not wake core");
   a_done_one: assert property (p_done_one)
      else $error("done longer than one cycle");
   a_pready: assert property (p_pready)
      else $error("bus answer not in second access cycle");
   c_pulse: cover property ($fell(reset_out_line_out));
   c_wake: cover property ($fell(stopped_out));
   c_format: cover property (exc_out.kind == sco_pkg::SCO_EXC_FORMAT);
endmodule : sco_ctrl_monitor

bind sco_ctrl sco_ctrl_monitor #(.LONG_CNT(LONG_CNT), .SHORT_CNT(SHORT_CNT))
   u_mon (.clk_sys_in, .resetn_in, .psel_in, .penable_in, .pready_out,
          .issue_valid_in, .opcode_in, .imm_in, .issue_ready_out, .done_out,
          .irq_level_in, .ext_reset_in, .reset_out_line_out, .exc_out,
          .status_word_out, .stopped_out);

// *** verif/sco_stack_mem.sv ***
// Stack memory and reset line listener beside the control block
`timescale 1ns/100ps
module sco_stack_mem (
   // Clock and reset
   input  wire logic                  clk_sys_in,
   input  wire logic                  resetn_in,
   // Stack port
   input  wire sco_pkg::sco_mem_req_t mem_in,
   input  wire logic [3:0]            delay_in,
   output logic                       ack_out,
   output logic [15:0]                data_out,
   // Reset line
   input  wire logic                  line_in,
   output logic [9:0]                 len_out
);
   logic [15:0] mem [0:127];
   logic [3:0]  wait_q;
   logic [9:0]  run_q;
   ////////////////////////////////////////////////////////////////////
   // Released data toggles so a stale word can never look valid
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ack_out  <= 1'h0;
         data_out <= 16'h0000;
         wait_q   <= 4'h0;
         run_q    <= 10'h000;
         len_out  <= 10'h000;
      end else begin
         run_q <= line_in ? run_q + 10'h001 : 10'h000;
         if (!line_in && run_q != 10'h000) begin
            len_out <= run_q;
         end
         if (ack_out || !mem_in.req) begin
            ack_out  <= 1'h0;
            wait_q   <= 4'h0;
            data_out <= ~data_out;
         end else if (wait_q == delay_in) begin
            ack_out  <= 1'h1;
            data_out <= mem[mem_in.addr[7:1]];
         end else begin
            wait_q   <= wait_q + 4'h1;
            data_out <= ~data_out;
         end
      end
   end
endmodule : sco_stack_mem

// *** verif/supervisor_control_ops_test.sv ***
// Self-checking bench for the supervisor control operations block
`timescale 1ns/100ps
module supervisor_control_ops_test;
   localparam int unsigned LC = 8;
   localparam int unsigned SC = 4;
   logic clk_sys_in = 1'h0;
   logic resetn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic issue_valid_in, issue_ready_out, done_out, mem_ack_in, ext_reset_in;
   logic reset_out_line_out, stopped_out, irq_out;
   logic [7:0]            paddr_in;
   logic [31:0]           pwdata_in, prdata_out, rd;
   logic [15:0]           opcode_in, imm_in, mem_data_in, status_word_out;
   logic [2:0]            irq_level_in;
   logic [3:0]            dly;
   logic [9:0]            plen;
   sco_pkg::sco_mem_req_t mem_out;
   sco_pkg::sco_exc_t     exc_out, ex;
   int                    err_count, n_compared, hi_seen;
   logic [3:0]  fmt_tab [0:5] = '{4'h0, 4'h2, 4'h9, 4'hA, 4'hB, 4'h7};
   logic [31:0] add_tab [0:5] = '{32'h8, 32'hC, 32'h14, 32'h20, 32'h5C, 32'h0};
   logic [15:0] op_tab [0:2] = '{sco_pkg::OP_RESET, sco_pkg::OP_STOP,
                                 sco_pkg::OP_RTE};
   sco_ctrl #(.LONG_CNT(LC), .SHORT_CNT(SC)) uut (.clk_sys_in, .resetn_in,
      .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
      .pready_out, .pslverr_out, .issue_valid_in, .opcode_in, .imm_in,
      .issue_ready_out, .done_out, .mem_out, .mem_ack_in, .mem_data_in,
      .irq_level_in, .ext_reset_in, .reset_out_line_out, .exc_out,
      .status_word_out, .stopped_out, .irq_out);
   sco_stack_mem u_mem (.clk_sys_in, .resetn_in, .mem_in(mem_out),
      .delay_in(dly), .ack_out(mem_ack_in), .data_out(mem_data_in),
      .line_in(reset_out_line_out), .len_out(plen));
   always #5 clk_sys_in = ~clk_sys_in;
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_x(input sco_pkg::sco_exc_kind_t k);
      chk({29'h0, ex.kind}, {29'h0, k});
   endtask : chk_x
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'h1;
      do @(posedge clk_sys_in); while (pready_out !== 1'h1);
      rd = prdata_out;
      {psel_in, penable_in} <= 2'h0;
   endtask : apb
   task automatic issue(input logic [15:0] op, input logic [15:0] im);
      @(posedge clk_sys_in);
      issue_valid_in <= 1'h1;
      opcode_in <= op;
      imm_in <= im;
      do @(posedge clk_sys_in); while (issue_ready_out !== 1'h1);
      issue_valid_in <= 1'h0;
      hi_seen = 0;
      ex = '0;
   endtask : issue
   task automatic fin();
      do begin
         @(posedge clk_sys_in);
         if (reset_out_line_out === 1'h1) hi_seen++;
         if (exc_out.valid === 1'h1) ex = exc_out;
      end while (done_out !== 1'h1);
   endtask : fin
   task automatic test_done();
      if (err_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      err_count++;
      test_done();
   end
   initial begin
      {resetn_in, psel_in, penable_in, pwrite_in, issue_valid_in} = 5'h0;
      {paddr_in, pwdata_in, opcode_in, imm_in} = '0;
      {irq_level_in, ext_reset_in, dly, err_count, n_compared} = '0;
      repeat (20) @(posedge clk_sys_in);
      resetn_in <= 1'h1;
      chk({16'h0, status_word_out}, 32'h0000_2700);
      apb(1'h1, sco_pkg::A_PC, 32'h0000_0100);
      for (int m = 0; m < 2; m++) begin
         apb(1'h1, sco_pkg::A_CTRL, 32'(m));
         apb(1'h1, sco_pkg::A_IMASK, m ? 32'h0 : 32'hF);
         issue(sco_pkg::OP_RESET, 16'h0000);
         fin();
         chk({22'h0, plen}, m ? SC : LC);
         chk(32'(hi_seen), m ? SC : LC);
         apb(1'h0, sco_pkg::A_PC, 32'h0);
         chk(rd, 32'h0000_0102 + 32'(2 * m));
         chk({16'h0, status_word_out}, 32'h0000_2700);
         chk({31'h0, irq_out}, 32'(m == 0));
         apb(1'h1, sco_pkg::A_ISTAT, 32'h1);
         apb(1'h0, sco_pkg::A_ISTAT, 32'h0);
         chk({rd[0], irq_out}, 32'h0);
      end
      for (int k = 0; k < 6; k++) begin
         apb(1'h1, sco_pkg::A_SW, 32'h0000_2700);
         apb(1'h1, sco_pkg::A_SP, 32'h0000_0040);
         dly <= 4'(k);
         u_mem.mem[32] = 16'h2210 + 16'(k);
         u_mem.mem[33] = 16'h0001;
         u_mem.mem[34] = 16'(4 * k);
         u_mem.mem[35] = {fmt_tab[k], 12'h008};
         issue(sco_pkg::OP_RTE, 16'h0000);
         fin();
         apb(1'h0, sco_pkg::A_SP, 32'h0);
         chk(rd, 32'h0000_0040 + add_tab[k]);
         chk({16'h0, status_word_out}, k < 5 ? 32'h2210 + k : 32'h2700);
         apb(1'h0, sco_pkg::A_PC, 32'h0);
         if (k < 5) chk(rd, 32'h0001_0000 + 32'(4 * k));
         else chk_x(sco_pkg::SCO_EXC_FORMAT);
      end
      apb(1'h1, sco_pkg::A_SW, 32'h0000_2700);
      apb(1'h1, sco_pkg::A_PC, 32'h0000_0200);
      issue(sco_pkg::OP_STOP, 16'h2315);
      irq_level_in <= 3'h3;
      repeat (6) @(posedge clk_sys_in);
      chk({31'h0, stopped_out}, 32'h1);
      chk({16'h0, status_word_out}, 32'h0000_2315);
      apb(1'h0, sco_pkg::A_PC, 32'h0);
      chk(rd, 32'h0000_0204);
      irq_level_in <= 3'h4;
      fin();
      chk_x(sco_pkg::SCO_EXC_IRQ);
      chk({29'h0, ex.level}, 32'h4);
      irq_level_in <= 3'h7;
      issue(sco_pkg::OP_STOP, 16'h2715);
      repeat (4) @(posedge clk_sys_in);
      chk({31'h0, stopped_out}, 32'h1);
      ext_reset_in <= 1'h1;
      fin();
      chk_x(sco_pkg::SCO_EXC_RESET);
      {ext_reset_in, irq_level_in} <= 4'h0;
      apb(1'h1, sco_pkg::A_SW, 32'h0000_6700);
      issue(sco_pkg::OP_STOP, 16'h6700);
      fin();
      chk_x(sco_pkg::SCO_EXC_TRACE);
      for (int k = 0; k < 3; k++) begin
         apb(1'h1, sco_pkg::A_SW, 32'h0000_0700);
         issue(op_tab[k], 16'h2700);
         fin();
         chk_x(sco_pkg::SCO_EXC_PRIV);
         chk(32'(hi_seen), 32'h0);
         chk({16'h0, status_word_out}, 32'h0000_0700);
      end
      apb(1'h0, 8'h1C, 32'h0);
      chk(rd, 32'h0);
      test_done();
   end
endmodule : supervisor_control_ops_test
